// File: src/query_readback_registers.sv
// Purpose: query command interpreter with output buffer for USB and SPI readback
// Assumes: register writes arrive as address plus data byte pulses
// Notes:   the output buffer is shared by both paths
// Functional notes
// - state mode 0 saves present configuration as power-up default.
// - state mode 1 returns present RF frequency in MHz.
// - state mode 2 returns tuning step size in MHz.
// - state mode 3 returns channel one conversion gain float.
// - state mode 4 returns channel two conversion gain float.
// - state mode 5 returns four attenuator bytes, chan two atten two highest.
// - state result appears on USB word and SPI return buffer.
// - host writes zero to status query; device loads 16-bit status.
// - status bits 15,14,13 report reference, first, second loop lock.
// - status bit 12 set when temperature exceeds 75 degC.
// - status bit 11 set when external reference detected.
// - bits 10,9,8 reference lock, monitor ports, standby; 7:0 reserved.
// - USB carries status in first two bytes; host reads two.
// - SPI carries status in last two of four bytes.
// - temperature query returns raw 32-bit float word.
// - info query loads item chosen by three-bit type field.
// - info codes serial, hw rev, fw rev, manufacture date, calibration date.
// - info result readable on USB at once, no further command.
// - SPI read of return buffer delivers result and clears buffer.
// - serial and dates unsigned, revisions float words.
// - dates pack year, month, day, hour from top byte down.
`timescale 1ns/10ps
`default_nettype none
module query_readback_registers #(
   parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001, // arbitrary value
   parameter logic [31:0] HW_REVISION   = 32'h3F80_0000,
   parameter logic [31:0] FW_REVISION   = 32'h3F80_0000,
   parameter logic [31:0] CAL_DATE      = 32'h0000_0000,
   parameter logic [7:0]  MFG_YEAR      = 8'h0F,
   parameter logic [7:0]  MFG_MONTH     = 8'h01,
   parameter logic [7:0]  MFG_DAY       = 8'h01,
   parameter logic [7:0]  MFG_HOUR      = 8'h00
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // register command port
   input  wire logic        cmd_wr,
   input  wire logic [7:0]  cmd_addr,
   input  wire logic [7:0]  cmd_data,
   input  wire logic        spi_return_rd,
   // device state inputs
   input  wire logic [31:0] rf_freq_mhz,
   input  wire logic [31:0] tune_step_mhz,
   input  wire logic [31:0] gain_chan_one,
   input  wire logic [31:0] gain_chan_two,
   input  wire logic [7:0]  chan_one_atten_one,
   input  wire logic [7:0]  chan_one_atten_two,
   input  wire logic [7:0]  chan_two_atten_one,
   input  wire logic [7:0]  chan_two_atten_two,
   input  wire logic [31:0] temperature_word,
   input  wire logic signed [15:0] temperature_degc,
   input  wire logic        ref_lock,
   input  wire logic        first_oscillator_lock,
   input  wire logic        second_oscillator_lock,
   input  wire logic        ext_ref_detect,
   input  wire logic        ref_lock_enabled,
   input  wire logic        monitor_enabled,
   input  wire logic        standby_active,
   // readback
   output logic [31:0]      usb_word,
   output logic [31:0]      spi_return_word,
   output logic             result_valid,
   output logic             save_default,
   output logic             overheat_flag
);
   info_bus_if ibus ();
   // decoded query strobes
   logic        state_hit;
   logic        status_hit;
   logic        temp_hit;
   logic        info_hit;
   logic        return_hit;
   logic        fetch_now;
   logic        mode_loads;
   logic        over_limit;
   // command fields
   logic [2:0]  mode_field;
   logic [2:0]  info_sel;
   // result sources
   logic [31:0] mfg_date_word;
   logic [31:0] info_word;
   logic [31:0] state_word;
   logic [31:0] atten_word;
   logic [15:0] status_word;
   // output buffer
   logic [31:0] buffer_reg;
   logic [31:0] buffer_next;
   logic        load_now;
   logic        fetch_date_reg;
   query_pkg::query_state_t state_reg;

   // one address decoder shared by every query strobe
   function automatic logic write_hits(
      input logic       wr,
      input logic [7:0] addr,
      input logic [7:0] target
   );
      return wr && (addr == target);
   endfunction

   // modes 0, 6 and 7 leave the buffer untouched
   function automatic logic mode_has_result(
      input logic [2:0] mode
   );
      case (mode)
         query_pkg::MODE_FREQ:     return 1'b1;
         query_pkg::MODE_STEP:     return 1'b1;
         query_pkg::MODE_GAIN_ONE: return 1'b1;
         query_pkg::MODE_GAIN_TWO: return 1'b1;
         query_pkg::MODE_ATTEN:    return 1'b1;
         default:                  return 1'b0;
      endcase
   endfunction

   // signed compare, so a reading below zero never looks hot
   function automatic logic above_limit(
      input logic signed [15:0] degc
   );
      return degc > 16'(query_pkg::TEMP_LIMIT_DEGC);
   endfunction

   // manufacture date, year in the top byte
   date_packer u_date (
      .year  (MFG_YEAR),
      .month (MFG_MONTH),
      .day   (MFG_DAY),
      .hour  (MFG_HOUR),
      .word  (mfg_date_word)
   );

   // store slot 3 is never shown: the packed date stands in for it
   unit_info_store #(
      .SERIAL_NUMBER (SERIAL_NUMBER),
      .HW_REVISION   (HW_REVISION),
      .FW_REVISION   (FW_REVISION),
      .CAL_DATE      (CAL_DATE)
   ) u_store (
      .clk   (clk),
      .rst_n (rst_n),
      .bus   (ibus.store)
   );

   // query strobes, one per register address
   assign state_hit  = write_hits(cmd_wr, cmd_addr, query_pkg::STATE_QUERY_ADDR);
   assign status_hit = write_hits(cmd_wr, cmd_addr, query_pkg::STATUS_QUERY_ADDR);
   assign temp_hit   = write_hits(cmd_wr, cmd_addr, query_pkg::TEMP_QUERY_ADDR);
   assign info_hit   = write_hits(cmd_wr, cmd_addr, query_pkg::INFO_QUERY_ADDR);
   // a query write in the same cycle wins over the return read
   assign return_hit = spi_return_rd && !cmd_wr;
   assign fetch_now  = (state_reg == query_pkg::ST_FETCH);

   // reserved command bits never reach the decoders
   assign mode_field = cmd_data[2:0];
   assign info_sel   = cmd_data[query_pkg::SEL_W-1:0];
   assign mode_loads = mode_has_result(mode_field);
   assign over_limit = above_limit(temperature_degc);

   // info lookup through the registered store
   assign ibus.sel = info_sel;
   assign ibus.rd  = info_hit;

   // remembers a date request, whose word comes from the packer instead
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_date_reg <= 1'b0;
      end else begin
         fetch_date_reg <= info_hit && (info_sel == query_pkg::INFO_MFG_DATE);
      end
   end
   assign info_word = fetch_date_reg ? mfg_date_word : ibus.data;

   // attenuators, channel two attenuator two in the top byte
   assign atten_word = {chan_two_atten_two,
                        chan_two_atten_one,
                        chan_one_atten_two,
                        chan_one_atten_one};

   always_comb begin
      state_word = query_pkg::BUFFER_RESET;
      case (mode_field)
         query_pkg::MODE_FREQ:     state_word = rf_freq_mhz;
         query_pkg::MODE_STEP:     state_word = tune_step_mhz;
         query_pkg::MODE_GAIN_ONE: state_word = gain_chan_one;
         query_pkg::MODE_GAIN_TWO: state_word = gain_chan_two;
         query_pkg::MODE_ATTEN:    state_word = atten_word;
         default:                  state_word = query_pkg::BUFFER_RESET;
      endcase
   end

   // status word, one field per line; low byte reserved
   assign status_word = {ref_lock,
                         first_oscillator_lock,
                         second_oscillator_lock,
                         over_limit,
                         ext_ref_detect,
                         ref_lock_enabled,
                         monitor_enabled,
                         standby_active,
                         8'h00};

   // info reads take one extra cycle through the registered store
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= query_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            query_pkg::ST_IDLE:  state_reg <= info_hit ? query_pkg::ST_FETCH : query_pkg::ST_IDLE;
            query_pkg::ST_FETCH: state_reg <= query_pkg::ST_LOAD;
            query_pkg::ST_LOAD:  state_reg <= query_pkg::ST_IDLE;
            default:             state_reg <= query_pkg::ST_IDLE;
         endcase
      end
   end

   always_comb begin
      buffer_next = buffer_reg;
      if (fetch_now) begin
         buffer_next = info_word;
      end else if (state_hit) begin
         if (mode_loads) begin
            buffer_next = state_word;
         end
      end else if (status_hit) begin
         // status held high for USB, low for SPI
         buffer_next = {status_word, status_word};
      end else if (temp_hit) begin
         buffer_next = temperature_word;
      end else if (return_hit) begin
         buffer_next = query_pkg::BUFFER_RESET;
      end
   end

   // any query that carries a result marks the buffer valid
   always_comb begin
      load_now = 1'b0;
      if (fetch_now) begin
         load_now = 1'b1;
      end else if (state_hit) begin
         load_now = mode_loads;
      end else if (status_hit || temp_hit) begin
         load_now = 1'b1;
      end
   end

   // the buffer itself; both output flops load the same next value beside it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buffer_reg <= query_pkg::BUFFER_RESET;
      end else begin
         buffer_reg <= buffer_next;
      end
   end

   // both paths read the same word, each from its own flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         usb_word <= query_pkg::BUFFER_RESET;
      end else begin
         usb_word <= buffer_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spi_return_word <= query_pkg::BUFFER_RESET;
      end else begin
         spi_return_word <= buffer_next;
      end
   end

   // a fresh load wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_valid <= 1'b0;
      end else if (load_now) begin
         result_valid <= 1'b1;
      end else if (return_hit) begin
         result_valid <= 1'b0;
      end
   end

   // one-cycle request to the configuration store
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         save_default <= 1'b0;
      end else begin
         save_default <= state_hit && (mode_field == query_pkg::MODE_SAVE);
      end
   end

   // level output, one cycle behind the temperature input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overheat_flag <= 1'b0;
      end else begin
         overheat_flag <= over_limit;
      end
   end
endmodule // query_readback_registers
`default_nettype wire

// File: src/query_pkg.sv
// Purpose: shared constants for the query and readback block
// Assumes: byte-wide register command port, 8-bit register addresses
// Notes:   offsets are the printed register addresses
package query_pkg;
   localparam logic [7:0] STATE_QUERY_ADDR   = 8'h19;
   localparam logic [7:0] STATUS_QUERY_ADDR  = 8'h1A;
   localparam logic [7:0] TEMP_QUERY_ADDR    = 8'h1B;
   localparam logic [7:0] INFO_QUERY_ADDR    = 8'h1C;
   localparam logic [7:0] SERIAL_RETURN_ADDR = 8'h1D;
   localparam logic [2:0] MODE_SAVE          = 3'h0;
   localparam logic [2:0] MODE_FREQ          = 3'h1;
   localparam logic [2:0] MODE_STEP          = 3'h2;
   localparam logic [2:0] MODE_GAIN_ONE      = 3'h3;
   localparam logic [2:0] MODE_GAIN_TWO      = 3'h4;
   localparam logic [2:0] MODE_ATTEN         = 3'h5;
   localparam logic [2:0] INFO_SERIAL        = 3'h0;
   localparam logic [2:0] INFO_HW_REV        = 3'h1;
   localparam logic [2:0] INFO_FW_REV        = 3'h2;
   localparam logic [2:0] INFO_MFG_DATE      = 3'h3;
   localparam logic [2:0] INFO_CAL_DATE      = 3'h4;
   localparam int         SEL_W              = 3;
   localparam int         TEMP_LIMIT_DEGC    = 75;
   localparam logic [31:0] BUFFER_RESET      = 32'h0000_0000;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_LOAD  = 2'b10
   } query_state_t;
endpackage

// File: src/info_bus_if.sv
// Purpose: carrier between the interpreter and the unit information store
// Assumes: one read per request, data one cycle later
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface info_bus_if;
   logic [2:0]  sel;
   logic        rd;
   logic [31:0] data;
   modport reader (output sel, output rd, input data);
   modport store  (input sel, input rd, output data);
endinterface
`default_nettype wire

// File: src/unit_info_store.sv
// Purpose: small memory of unit information words
// Assumes: contents fixed at build time
// Notes:   read data registered; unused codes read as zero
`timescale 1ns/10ps
`default_nettype none
module unit_info_store #(
   parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001, // arbitrary value
   parameter logic [31:0] HW_REVISION   = 32'h3F80_0000,
   parameter logic [31:0] FW_REVISION   = 32'h3F80_0000,
   parameter logic [31:0] MFG_DATE      = 32'h0101_0100,
   parameter logic [31:0] CAL_DATE      = 32'h0000_0000
) (
   // clock and reset
   input  wire logic  clk,
   input  wire logic  rst_n,
   // lookup port
   info_bus_if.store  bus
);
   logic [31:0] rom [0:7];
   assign rom[0] = SERIAL_NUMBER;
   assign rom[1] = HW_REVISION;
   assign rom[2] = FW_REVISION;
   assign rom[3] = MFG_DATE;
   assign rom[4] = CAL_DATE;
   assign rom[5] = 32'h0000_0000;
   assign rom[6] = 32'h0000_0000;
   assign rom[7] = 32'h0000_0000;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus.data <= 32'h0000_0000;
      end else if (bus.rd) begin
         bus.data <= rom[bus.sel];
      end
   end
endmodule // unit_info_store
`default_nettype wire

// File: src/date_packer.sv
// Purpose: packs date fields into one word
// Assumes: fields already binary
// Notes:   combinational
`timescale 1ns/10ps
`default_nettype none
module date_packer (
   // fields
   input  wire logic [7:0]  year,
   input  wire logic [7:0]  month,
   input  wire logic [7:0]  day,
   input  wire logic [7:0]  hour,
   // packed word
   output logic [31:0]      word
);
   assign word = {year, month, day, hour};
endmodule // date_packer
`default_nettype wire

// File: verif/query_monitor.sv
// Purpose: port checker for the query block
// Assumes: one clock, async low reset
// Notes:   status bit 12 is left to the bench, its timing is the designer's
`timescale 1ns/10ps
`default_nettype none
module query_monitor (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // commands
   input  wire logic        cmd_wr,
   input  wire logic [7:0]  cmd_addr,
   input  wire logic [7:0]  cmd_data,
   input  wire logic        spi_return_rd,
   // device state
   input  wire logic [31:0] rf_freq_mhz,
   input  wire logic [31:0] tune_step_mhz,
   input  wire logic [7:0]  chan_one_atten_one,
   input  wire logic [7:0]  chan_one_atten_two,
   input  wire logic [7:0]  chan_two_atten_one,
   input  wire logic [7:0]  chan_two_atten_two,
   input  wire logic [31:0] temperature_word,
   input  wire logic signed [15:0] temperature_degc,
   input  wire logic        ref_lock,
   input  wire logic        first_oscillator_lock,
   input  wire logic        second_oscillator_lock,
   input  wire logic        ext_ref_detect,
   input  wire logic        ref_lock_enabled,
   input  wire logic        monitor_enabled,
   input  wire logic        standby_active,
   // readback
   input  wire logic [31:0] usb_word,
   input  wire logic [31:0] spi_return_word,
   input  wire logic        result_valid,
   input  wire logic        save_default,
   input  wire logic        overheat_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic st;
   assign st = cmd_wr && cmd_addr == query_pkg::STATE_QUERY_ADDR;
   property p_freq; st && cmd_data[2:0] == 3'h1 |=> usb_word == $past(rf_freq_mhz); endproperty
   a_freq: assert property (p_freq) else $error("frequency readback wrong");
   property p_step; st && cmd_data[2:0] == 3'h2 |=> usb_word == $past(tune_step_mhz) && result_valid; endproperty
   a_step: assert property (p_step) else $error("step readback wrong");
   property p_atten; st && cmd_data[2:0] == 3'h5 |=> usb_word == {$past(chan_two_atten_two),
      $past(chan_two_atten_one), $past(chan_one_atten_two), $past(chan_one_atten_one)}; endproperty
   a_atten: assert property (p_atten) else $error("attenuator byte order wrong");
   property p_save; st && cmd_data[2:0] == 3'h0 |=> save_default; endproperty
   a_save: assert property (p_save) else $error("save pulse missing");
   property p_save_only; !($past(st) && $past(cmd_data[2:0]) == 3'h0) |-> !save_default; endproperty
   a_save_only: assert property (p_save_only) else $error("save pulse without command");
   property p_same; usb_word == spi_return_word; endproperty
   a_same: assert property (p_same) else $error("usb and spi views differ");
   property p_status; cmd_wr && cmd_addr == query_pkg::STATUS_QUERY_ADDR |=> usb_word[31:16] == usb_word[15:0]
      && usb_word[15:13] == {$past(ref_lock), $past(first_oscillator_lock), $past(second_oscillator_lock)}
      && usb_word[10:8] == {$past(ref_lock_enabled), $past(monitor_enabled), $past(standby_active)}
      && usb_word[11] == $past(ext_ref_detect) && usb_word[7:0] == 8'h00; endproperty
   a_status: assert property (p_status) else $error("status word wrong");
   property p_temp; cmd_wr && cmd_addr == query_pkg::TEMP_QUERY_ADDR |=> usb_word == $past(temperature_word); endproperty
   a_temp: assert property (p_temp) else $error("temperature word wrong");
   property p_hot; $past(rst_n) |-> overheat_flag == ($past(temperature_degc) > 16'sd75); endproperty
   a_hot: assert property (p_hot) else $error("overheat flag wrong");
   property p_clear; spi_return_rd && !cmd_wr |=> !result_valid && spi_return_word == 32'h0000_0000; endproperty
   a_clear: assert property (p_clear) else $error("return buffer not cleared");
endmodule // query_monitor
`default_nettype wire

// File: verif/host_model.sv
// Purpose: host side that writes query bytes and fetches the return buffer
// Assumes: changes on falling edges, one-cycle pulses
// Notes:   released lines show the inverse so stale values never pass
`timescale 1ns/10ps
`default_nettype none
module host_model (
   // clock
   input  wire logic clk,
   // command side
   output logic       cmd_wr = 1'b0,
   output logic [7:0] cmd_addr = 8'h00,
   output logic [7:0] cmd_data = 8'h00,
   output logic       spi_return_rd = 1'b0
);
   task automatic send(input logic [7:0] a, input logic [2:0] m);
      @(negedge clk);
      cmd_wr = 1'b1;
      cmd_addr = a;
      cmd_data = {5'h00, m};
      @(negedge clk);
      cmd_wr = 1'b0;
      cmd_addr = ~a;
      cmd_data = ~cmd_data;
   endtask
   // one pulse stands for the whole four-byte return transfer
   task automatic fetch();
      @(negedge clk);
      spi_return_rd = 1'b1;
      @(negedge clk);
      spi_return_rd = 1'b0;
   endtask
endmodule // host_model
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: self-checking bench for the query block
// Assumes: host model drives commands on falling edges
// Notes:   expected words come from a bench model queue
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_wr, spi_return_rd, ref_lock, first_oscillator_lock, second_oscillator_lock, ext_ref_detect;
   logic ref_lock_enabled, monitor_enabled, standby_active, result_valid, save_default, overheat_flag;
   logic [7:0] cmd_addr, cmd_data, chan_one_atten_one, chan_one_atten_two, chan_two_atten_one, chan_two_atten_two;
   logic [31:0] rf_freq_mhz, tune_step_mhz, gain_chan_one, gain_chan_two, temperature_word, usb_word, spi_return_word;
   logic signed [15:0] temperature_degc;
   int bad_count = 0;
   int total_checks = 0;
   int seed = 32'hBB59895A;
   logic [31:0] exp_q[$];
   // firmware revision, year and hour stay at the block's own defaults
   logic [31:0] info_tab [5] = '{32'h0000_1234, 32'h3FC0_0000, 32'h3F80_0000, 32'h0F0C_1F00, 32'h1803_0409};
   query_readback_registers #(.SERIAL_NUMBER(32'h0000_1234), .HW_REVISION(32'h3FC0_0000),
      .CAL_DATE(32'h1803_0409), .MFG_MONTH(8'h0C), .MFG_DAY(8'h1F)) DUT (.*);
   host_model host (.*);
   initial begin forever #12.5 clk = ~clk; end
   function automatic void roll();
      {rf_freq_mhz, tune_step_mhz} = {$random(seed), $random(seed)};
      {gain_chan_one, gain_chan_two, temperature_word} = {$random(seed), $random(seed), $random(seed)};
      {chan_one_atten_one, chan_one_atten_two, chan_two_atten_one, chan_two_atten_two} = $random(seed);
      {ref_lock, first_oscillator_lock, second_oscillator_lock, ext_ref_detect} = 4'($random(seed));
      {ref_lock_enabled, monitor_enabled, standby_active} = 3'($random(seed));
      temperature_degc = 16'(($random(seed) & 32'hFF) - 100); // straddles the threshold
   endfunction
   function automatic logic [31:0] model(input logic [7:0] a, input logic [2:0] m);
      logic [15:0] s;
      s = {ref_lock, first_oscillator_lock, second_oscillator_lock, temperature_degc > 16'sd75, ext_ref_detect,
           ref_lock_enabled, monitor_enabled, standby_active, 8'h00};
      case (a)
         8'h19: return m == 3'h1 ? rf_freq_mhz : m == 3'h2 ? tune_step_mhz : m == 3'h3 ? gain_chan_one :
                       m == 3'h4 ? gain_chan_two : {chan_two_atten_two, chan_two_atten_one, chan_one_atten_two,
                       chan_one_atten_one};
         8'h1A: return {s, s};
         8'h1B: return temperature_word;
         default: return info_tab[m];
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic query(input logic [7:0] a, input logic [2:0] m);
      @(negedge clk);
      roll();
      exp_q.push_back(model(a, m));
      host.send(a, m);
      // info answers one edge later than the other queries
      if (a == 8'h1C) @(negedge clk);
      check(usb_word, exp_q[0]);
      check(spi_return_word, exp_q.pop_front());
      check(result_valid, 1'b1);
      repeat (2) @(negedge clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      roll();
      repeat (6) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      for (int m = 1; m < 6; m++) query(8'h19, 3'(m));
      repeat (4) query(8'h1A, 3'h0);
      query(8'h1B, 3'h0);
      for (int m = 0; m < 5; m++) query(8'h1C, 3'(m));
      host.send(8'h19, 3'h0);
      check(save_default, 1'b1);
      check(usb_word, info_tab[4]);
      // unused mode and a write to the return address must leave the buffer alone
      host.send(8'h19, 3'h6);
      host.send(8'h1D, 3'h1);
      check(spi_return_word, info_tab[4]);
      host.fetch();
      check(spi_return_word, 32'h0000_0000);
      check(result_valid, 1'b0);
      check(overheat_flag, temperature_degc > 16'sd75);
      tally_and_finish();
   end
   initial begin
      #50000;
      bad_count++;
      tally_and_finish();
   end
endmodule // tb_top
bind query_readback_registers query_monitor mon (.*);
`default_nettype wire
